// >>> hdl/rgc_pkg.sv
// package of constants for the ramp generator control register bank
package rgc_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] RGC_OFF_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RGC_OFF_VOLT_SEL    = 8'h04;
    localparam logic [7:0] RGC_OFF_CONTROL_TWO = 8'h08;
    localparam logic [7:0] RGC_OFF_RISE_SEL    = 8'h0c;
    localparam logic [7:0] RGC_OFF_FALL_SEL    = 8'h10;
    localparam logic [7:0] RGC_OFF_EDGE_MODE   = 8'h14;
    // ==========================================================
    // field positions
    localparam int RGC_BIT_READY       = 2;
    localparam int RGC_BIT_FALL_POL    = 1;
    localparam int RGC_BIT_RISE_POL    = 0;
    localparam int RGC_BIT_LOW_RANGE   = 7;
    localparam int RGC_BIT_FALL_EDGE   = 1;
    localparam int RGC_BIT_RISE_EDGE   = 0;
    localparam logic [7:0] RGC_MASK_CONTROL_ONE = 8'h03;
    localparam logic [7:0] RGC_MASK_SELECT      = 8'h0f;
    localparam logic [7:0] RGC_MASK_CONTROL_TWO = 8'h9f;
    localparam logic [7:0] RGC_MASK_EDGE_MODE   = 8'h03;
    localparam logic [7:0] RGC_RESET_VALUE      = 8'h00;
    // ==========================================================
    // decoded counts
    localparam int RGC_NUM_VOLT_SRC   = 9;
    localparam int RGC_NUM_TIMING_SRC = 11;
    localparam logic [3:0] RGC_VOLT_SW_IN0 = 4'h8;
    localparam logic [3:0] RGC_VOLT_SW_IN1 = 4'h9;
    // ==========================================================
    // bus answers
    localparam logic [1:0] RGC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RGC_RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/rgc_volt_decode.sv
// start voltage source one-hot decoder
`timescale 1ns/10ps
module rgc_volt_decode (
    input  wire logic [3:0]                          sel,
    input  wire logic                                override_tristate,
    output logic [rgc_pkg::RGC_NUM_VOLT_SRC-1:0]     onehot
);
    import rgc_pkg::*;
    // index: 0 in0, 1 in1, 2 reference_buffer_two, 3..6 converters 1..4, 7/8 switched in0/in1
    always_comb begin
        onehot = '0;
        unique case (sel)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
                onehot[sel[2:0]] = 1'b1; // [R6]
            end
            RGC_VOLT_SW_IN0: begin
                onehot[7] = ~override_tristate; // [R7]
            end
            RGC_VOLT_SW_IN1: begin
                onehot[8] = ~override_tristate; // [R7]
            end
            default: begin
                onehot = '0; // reserved codes select nothing [R6]
            end
        endcase
    end
endmodule // rgc_volt_decode

// >>> hdl/rgc_timing_select.sv
// timing source selector, polarity and edge/level conditioning
`timescale 1ns/10ps
module rgc_timing_select (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst_n,
    input  wire logic [3:0]                            sel,
    input  wire logic                                  active_low,
    input  wire logic                                  edge_mode,
    input  wire logic [rgc_pkg::RGC_NUM_TIMING_SRC-1:0] sources_sync,
    output logic                                       timing_out
);
    import rgc_pkg::*;
    logic picked;
    logic level;
    logic prev_q;
    logic prev_d;
    logic out_q;
    logic out_d;
    always_comb begin
        picked = (sel < 4'(RGC_NUM_TIMING_SRC)) ? sources_sync[sel] : 1'b0; // [R13]
        level  = picked ^ active_low;
        prev_d = level;
        out_d  = edge_mode ? (level & ~prev_q) : level; // [R14]
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            out_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            out_q  <= out_d;
        end
    end
    assign timing_out = out_q;
endmodule // rgc_timing_select

// >>> hdl/rgc_regs.sv
// ramp generator control register bank with AXI4-Lite slave
// Operation
// R1: unimplemented upper bits of every register read back as zero
// R2: control one bit 2 is read-only ready flag, resets to zero
// R3: control one bit 1 makes falling timing input active low when set
// R4: control one bit 0 makes rising timing input active low when set
// R5: voltage select bits 3..0 pick the ramp start voltage source
// R6: voltage codes decode to inputs, buffer, converters, switched inputs; others reserved
// R7: switched inputs disconnect while op amp override forces tri-state
// R8: control two bit 7 enables low current range
// R9: control two bits 4..0 set current and slope, normal range
// R10: low range gives the same codes scaled current and slope
// R11: rise source bits 3..0 pick the rising timing signal
// R12: every field and ready flag clear to zero on reset
// R13: timing codes: comparators, pin, pulse-width, capture outputs; rest reserved
// R14: each timing input has its own edge or level mode bit
// R15: writes to ready flag and unimplemented bits are ignored
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module rgc_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst_n,
    input  wire logic [ADDR_W-1:0]                      s_axi_awaddr,
    input  wire logic                                   s_axi_awvalid,
    output logic                                        s_axi_awready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    input  wire logic                                   s_axi_wvalid,
    output logic                                        s_axi_wready,
    output logic [1:0]                                  s_axi_bresp,
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]                      s_axi_araddr,
    input  wire logic                                   s_axi_arvalid,
    output logic                                        s_axi_arready,
    output logic [31:0]                                 s_axi_rdata,
    output logic [1:0]                                  s_axi_rresp,
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    input  wire logic                                   generator_ready,
    input  wire logic                                   override_tristate,
    input  wire logic [rgc_pkg::RGC_NUM_TIMING_SRC-1:0] timing_sources,
    output logic [rgc_pkg::RGC_NUM_VOLT_SRC-1:0]        start_voltage_onehot,
    output logic [4:0]                                  current_setting,
    output logic                                        low_current_range,
    output logic                                        rise_timing,
    output logic                                        fall_timing
);
    import rgc_pkg::*;

    // the address decode slices bits 4..0 and 5 upwards, so at least six bits are needed
    if (ADDR_W < 6) begin : g_addr_w_check
        $error("rgc_regs: ADDR_W must be at least 6");
    end

    // ==========================================================
    // input synchronisers
    logic        ready_s1_q;
    logic        ready_s2_q;
    logic        ovr_s1_q;
    logic        ovr_s2_q;
    logic [RGC_NUM_TIMING_SRC-1:0] src_s1_q;
    logic [RGC_NUM_TIMING_SRC-1:0] src_s2_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ready_s1_q <= 1'b0;
            ready_s2_q <= 1'b0; // [R12]
            ovr_s1_q   <= 1'b0;
            ovr_s2_q   <= 1'b0;
            src_s1_q   <= '0;
            src_s2_q   <= '0;
        end else begin
            ready_s1_q <= generator_ready;
            ready_s2_q <= ready_s1_q;
            ovr_s1_q   <= override_tristate;
            ovr_s2_q   <= ovr_s1_q;
            src_s1_q   <= timing_sources;
            src_s2_q   <= src_s1_q;
        end
    end

    // ==========================================================
    // register state
    logic [7:0] ctl_one_q;
    logic [7:0] ctl_one_d;
    logic [7:0] volt_sel_q;
    logic [7:0] volt_sel_d;
    logic [7:0] ctl_two_q;
    logic [7:0] ctl_two_d;
    logic [7:0] rise_sel_q;
    logic [7:0] rise_sel_d;
    logic [7:0] fall_sel_q;
    logic [7:0] fall_sel_d;
    logic [7:0] edge_q;
    logic [7:0] edge_d;

    // ==========================================================
    // write channel: address and data taken in either order
    logic              aw_held_q;
    logic              aw_held_d;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [ADDR_W-1:0] aw_addr_d;
    logic              w_held_q;
    logic              w_held_d;
    logic [31:0]       w_data_q;
    logic [31:0]       w_data_d;
    logic              w_strb0_q;
    logic              w_strb0_d;
    logic              bvalid_q;
    logic              bvalid_d;
    logic [1:0]        bresp_q;
    logic [1:0]        bresp_d;
    logic              awready_q;
    logic              awready_d;
    logic              wready_q;
    logic              wready_d;
    logic              do_write;
    logic              w_hit;
    logic [7:0]        wbyte;

    always_comb begin
        aw_held_d  = aw_held_q;
        aw_addr_d  = aw_addr_q;
        w_held_d   = w_held_q;
        w_data_d   = w_data_q;
        w_strb0_d  = w_strb0_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        ctl_one_d  = ctl_one_q;
        volt_sel_d = volt_sel_q;
        ctl_two_d  = ctl_two_q;
        rise_sel_d = rise_sel_q;
        fall_sel_d = fall_sel_q;
        edge_d     = edge_q;
        w_hit      = 1'b0;
        wbyte      = w_data_q[7:0];
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d  = 1'b1;
            w_data_d  = s_axi_wdata;
            w_strb0_d = s_axi_wstrb[0];
        end
        do_write = aw_held_q && w_held_q && !bvalid_q;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            w_hit     = 1'b1;
            unique case (aw_addr_q[4:0])
                RGC_OFF_CONTROL_ONE[4:0]: begin
                    if (w_strb0_q) ctl_one_d = wbyte & RGC_MASK_CONTROL_ONE; // [R3] [R4] [R15]
                end
                RGC_OFF_VOLT_SEL[4:0]: begin
                    if (w_strb0_q) volt_sel_d = wbyte & RGC_MASK_SELECT; // [R5] [R15]
                end
                RGC_OFF_CONTROL_TWO[4:0]: begin
                    if (w_strb0_q) ctl_two_d = wbyte & RGC_MASK_CONTROL_TWO; // [R8] [R9] [R15]
                end
                RGC_OFF_RISE_SEL[4:0]: begin
                    if (w_strb0_q) rise_sel_d = wbyte & RGC_MASK_SELECT; // [R11] [R15]
                end
                RGC_OFF_FALL_SEL[4:0]: begin
                    if (w_strb0_q) fall_sel_d = wbyte & RGC_MASK_SELECT; // [R15]
                end
                RGC_OFF_EDGE_MODE[4:0]: begin
                    if (w_strb0_q) edge_d = wbyte & RGC_MASK_EDGE_MODE; // [R14] [R15]
                end
                default: begin
                    w_hit = 1'b0;
                end
            endcase
            if (aw_addr_q[ADDR_W-1:5] != '0) begin
                w_hit = 1'b0;
            end
            bresp_d = w_hit ? RGC_RESP_OKAY : RGC_RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // ready low while a half is held keeps one write in flight
        awready_d = !aw_held_d;
        wready_d  = !w_held_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_held_q  <= 1'b0;
            aw_addr_q  <= '0;
            w_held_q   <= 1'b0;
            w_data_q   <= '0;
            w_strb0_q  <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RGC_RESP_OKAY;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            ctl_one_q  <= RGC_RESET_VALUE; // [R12]
            volt_sel_q <= RGC_RESET_VALUE; // [R12]
            ctl_two_q  <= RGC_RESET_VALUE; // [R12]
            rise_sel_q <= RGC_RESET_VALUE; // [R12]
            fall_sel_q <= RGC_RESET_VALUE; // [R12]
            edge_q     <= RGC_RESET_VALUE; // [R12]
        end else begin
            aw_held_q  <= aw_held_d;
            aw_addr_q  <= aw_addr_d;
            w_held_q   <= w_held_d;
            w_data_q   <= w_data_d;
            w_strb0_q  <= w_strb0_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            ctl_one_q  <= ctl_one_d;
            volt_sel_q <= volt_sel_d;
            ctl_two_q  <= ctl_two_d;
            rise_sel_q <= rise_sel_d;
            fall_sel_q <= fall_sel_d;
            edge_q     <= edge_d;
        end
    end

    // ==========================================================
    // read channel
    logic        arready_q;
    logic        arready_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic [7:0]  rbyte;
    logic        r_hit;

    always_comb begin
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rbyte     = 8'h00;
        r_hit     = 1'b1;
        unique case (s_axi_araddr[4:0])
            RGC_OFF_CONTROL_ONE[4:0]: begin
                rbyte = ctl_one_q & RGC_MASK_CONTROL_ONE; // [R1]
                rbyte[RGC_BIT_READY] = ready_s2_q; // [R2]
            end
            RGC_OFF_VOLT_SEL[4:0]: rbyte = volt_sel_q & RGC_MASK_SELECT; // [R1]
            RGC_OFF_CONTROL_TWO[4:0]: rbyte = ctl_two_q & RGC_MASK_CONTROL_TWO; // [R1]
            RGC_OFF_RISE_SEL[4:0]: rbyte = rise_sel_q & RGC_MASK_SELECT; // [R1]
            RGC_OFF_FALL_SEL[4:0]: rbyte = fall_sel_q & RGC_MASK_SELECT; // [R1]
            RGC_OFF_EDGE_MODE[4:0]: rbyte = edge_q & RGC_MASK_EDGE_MODE; // [R1]
            default: r_hit = 1'b0;
        endcase
        if (s_axi_araddr[ADDR_W-1:5] != '0) begin
            r_hit = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = r_hit ? {24'h000000, rbyte} : 32'h00000000;
            rresp_d  = r_hit ? RGC_RESP_OKAY : RGC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d && !(s_axi_arvalid && arready_q);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RGC_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // ==========================================================
    // steering outputs
    logic [RGC_NUM_VOLT_SRC-1:0] volt_onehot;
    logic [RGC_NUM_VOLT_SRC-1:0] volt_q;
    logic [4:0]                  current_setting_q;
    logic                        lr_q;

    rgc_volt_decode u_volt (
        .sel               (volt_sel_q[3:0]),
        .override_tristate (ovr_s2_q),
        .onehot            (volt_onehot)
    );

    rgc_timing_select u_rise (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sel          (rise_sel_q[3:0]),
        .active_low   (ctl_one_q[RGC_BIT_RISE_POL]),
        .edge_mode    (edge_q[RGC_BIT_RISE_EDGE]),
        .sources_sync (src_s2_q),
        .timing_out   (rise_timing)
    );

    rgc_timing_select u_fall (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sel          (fall_sel_q[3:0]),
        .active_low   (ctl_one_q[RGC_BIT_FALL_POL]),
        .edge_mode    (edge_q[RGC_BIT_FALL_EDGE]),
        .sources_sync (src_s2_q),
        .timing_out   (fall_timing)
    );

    // analog trim takes code and range as is; the table lives in the analog block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            volt_q <= '0;
            current_setting_q <= '0;
            lr_q   <= 1'b0;
        end else begin
            volt_q <= volt_onehot;
            current_setting_q <= ctl_two_q[4:0]; // [R9] [R10]
            lr_q   <= ctl_two_q[RGC_BIT_LOW_RANGE]; // [R8] [R10]
        end
    end

    assign start_voltage_onehot = volt_q;
    assign current_setting      = current_setting_q;
    assign low_current_range    = lr_q;
    assign s_axi_awready        = awready_q;
    assign s_axi_wready         = wready_q;
    assign s_axi_bvalid         = bvalid_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = arready_q;
    assign s_axi_rvalid         = rvalid_q;
    assign s_axi_rdata          = rdata_q;
    assign s_axi_rresp          = rresp_q;
endmodule // rgc_regs

// >>> test/rgc_regs_props.sv
// concurrent checks on the ports of the ramp generator control register bank
`timescale 1ns/10ps
module rgc_regs_props
    import rgc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic                        sys_clk,
    input wire logic                        rst_n,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [ADDR_W-1:0]           s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        override_tristate,
    input wire logic [RGC_NUM_VOLT_SRC-1:0] start_voltage_onehot,
    input wire logic [4:0]                  current_setting,
    input wire logic                        low_current_range
);
    // ==========================================================
    // bus and output relations
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence unmapped_read;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h14);
    endsequence

    a_reset_clears_outputs: assert property ($rose(rst_n) |-> current_setting == 5'h00
        && !low_current_range && start_voltage_onehot == '0) else $error("outputs not clear");
    a_write_answer_due: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer_due: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_refused_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_read_err: assert property (unmapped_read |=> s_axi_rvalid
        && s_axi_rresp == RGC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    a_volt_single_src: assert property ($onehot0(start_voltage_onehot))
        else $error("several voltage sources");
    a_switched_off_ovr: assert property (override_tristate [*5] |->
        start_voltage_onehot[8:7] == 2'b00) else $error("switched input left on");
endmodule // rgc_regs_props

// >>> test/test_rgc_regs.sv
// self-checking bench for the ramp generator control register bank
`timescale 1ns/10ps
module test_rgc_regs;
    import rgc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        generator_ready = 1'b0, override_tristate = 1'b0;
    logic [10:0] timing_sources = 11'h000;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        rise_timing, fall_timing, low_current_range;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [8:0]  start_voltage_onehot;
    logic [4:0]  current_setting;
    int          err_count = 0, num_checks = 0, cyc = 0;
    localparam logic [7:0] OFFS [6] = '{RGC_OFF_CONTROL_ONE, RGC_OFF_VOLT_SEL,
        RGC_OFF_CONTROL_TWO, RGC_OFF_RISE_SEL, RGC_OFF_FALL_SEL, RGC_OFF_EDGE_MODE};
    localparam logic [7:0] MSKS [6] = '{RGC_MASK_CONTROL_ONE, RGC_MASK_SELECT,
        RGC_MASK_CONTROL_TWO, RGC_MASK_SELECT, RGC_MASK_SELECT, RGC_MASK_EDGE_MODE};

    rgc_regs u_rgc_regs (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .generator_ready, .override_tristate,
        .timing_sources, .start_voltage_onehot, .current_setting, .low_current_range,
        .rise_timing, .fall_timing);

    always #2.5 sys_clk = ~sys_clk;

    // ==========================================================
    // reporting and bus tasks
    task automatic close_out;
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // bready comes late on purpose so the response must stand
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    function automatic logic [31:0] volt_exp(input int c, input logic ovr);
        if (c <= 6) return 32'h1 << c;
        if (c == 8 && !ovr) return 32'h080;
        if (c == 9 && !ovr) return 32'h100;
        return 32'h0;
    endfunction

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    // ==========================================================
    // scenarios
    initial begin
        logic        e;
        logic [31:0] n;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            rd(OFFS[i], 32'h0, RGC_RESP_OKAY);
            wr(OFFS[i], 8'hff, RGC_RESP_OKAY);
            rd(OFFS[i], {24'h0, MSKS[i]}, RGC_RESP_OKAY);
            wr(OFFS[i], 8'h00, RGC_RESP_OKAY);
        end
        generator_ready <= 1'b1;
        wr(RGC_OFF_CONTROL_ONE, 8'h00, RGC_RESP_OKAY);
        rd(RGC_OFF_CONTROL_ONE, 32'h4, RGC_RESP_OKAY);
        generator_ready <= 1'b0;
        wr(8'h18, 8'h5a, RGC_RESP_SLVERR);
        rd(8'h18, 32'h0, RGC_RESP_SLVERR);
        wr(RGC_OFF_CONTROL_TWO, 8'h9f, RGC_RESP_OKAY);
        tick(2);
        check("current", 32'h1f, {27'h0, current_setting});
        check("low_range", 32'h1, {31'h0, low_current_range});
        wr(RGC_OFF_CONTROL_TWO, 8'h06, RGC_RESP_OKAY);
        tick(2);
        check("current", 32'h06, {27'h0, current_setting});
        check("low_range", 32'h0, {31'h0, low_current_range});
        for (int o = 0; o < 2; o++) begin
            @(posedge sys_clk);
            override_tristate <= o[0];
            tick(5);
            for (int c = 0; c < 16; c++) begin
                wr(RGC_OFF_VOLT_SEL, c[7:0], RGC_RESP_OKAY);
                tick(2);
                n = volt_exp(c, o[0]);
                check("voltage", n, {23'h0, start_voltage_onehot});
            end
        end
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 2; p++) begin
                wr(RGC_OFF_RISE_SEL, c[7:0], RGC_RESP_OKAY);
                wr(RGC_OFF_FALL_SEL, c[7:0], RGC_RESP_OKAY);
                wr(RGC_OFF_CONTROL_ONE, p[0] ? 8'h03 : 8'h00, RGC_RESP_OKAY);
                for (int k = 0; k < 2; k++) begin
                    @(posedge sys_clk);
                    timing_sources <= k[0] ? ~(11'h1 << c) : (11'h1 << c);
                    tick(5);
                    // reserved codes select nothing, so only the polarity shows
                    e = (c < 11) ? ((k == 0) != (p == 1)) : (p == 1);
                    check("rise", {31'h0, e}, {31'h0, rise_timing});
                    check("fall", {31'h0, e}, {31'h0, fall_timing});
                end
            end
        end
        wr(RGC_OFF_CONTROL_ONE, 8'h00, RGC_RESP_OKAY);
        wr(RGC_OFF_RISE_SEL, 8'h04, RGC_RESP_OKAY);
        wr(RGC_OFF_FALL_SEL, 8'h04, RGC_RESP_OKAY);
        // first pass: rise in edge mode, fall in level mode; second pass swapped
        for (int m = 0; m < 2; m++) begin
            wr(RGC_OFF_EDGE_MODE, m[0] ? 8'h02 : 8'h01, RGC_RESP_OKAY);
            @(posedge sys_clk);
            timing_sources <= 11'h000;
            tick(5);
            @(posedge sys_clk);
            timing_sources <= 11'h010;
            n = 32'h0;
            repeat (10) begin
                tick(1);
                n = n + {31'h0, (m[0] ? fall_timing : rise_timing)};
            end
            check("edge_pulses", 32'h1, n);
            check("level_mode", 32'h1, {31'h0, (m[0] ? rise_timing : fall_timing)});
        end
        close_out();
    end
endmodule // test_rgc_regs

bind rgc_regs rgc_regs_props #(.ADDR_W(ADDR_W)) u_rgc_regs_props (.sys_clk, .rst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .override_tristate, .start_voltage_onehot, .current_setting,
    .low_current_range);
